// *** logic/fxos_cfg.svh ***
// Constants for the fixed-point output stage: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite master and byte addresses on aligned words.
//
// Behaviour
// - Default format represents the result exactly; user setting fixes width and fraction.
// - Output type selectable as unsigned or signed two's complement.
// - Output width is a parameter, up to 4096 bits.
// - Fraction bit count lies between zero and the output width.
// - Saturate clamps above range to largest, below range to smallest value.
// - Wrap drops all result bits above the output MSB.
// - Flag-as-error mode builds the same hardware as wrap.
// - Truncate drops all result bits below the output LSB.
// - Symmetric round to nearest, midpoints go away from zero.
// - Convergent round to nearest, midpoints go to even LSB.
// - Latency N delays output N sample periods via output shift register.
// - A sample period may span several clocks; state advances once per period.
// - Datapath reset returns all state, pipeline included, to initial values; the code leaves the sticky overflow status bit unchanged.
// - Datapath reset acts even while enable is low.
// - Enable low holds state until enable returns or reset is asserted.
// - Sample timing comes from a system-rate clock enable; reset acts on enabled cycles.
`ifndef FXOS_CFG_SVH
`define FXOS_CFG_SVH

// ============================================================
// Register byte offsets
`define FXOS_OFF_CTRL       12'h000
`define FXOS_OFF_STATUS     12'h004
`define FXOS_OFF_COUNT      12'h008
`define FXOS_OFF_FORMAT     12'h00c

// ============================================================
// Field positions
`define FXOS_CTRL_SIGNED    0
`define FXOS_CTRL_OVF_LO    1
`define FXOS_CTRL_Q_LO      3
`define FXOS_STAT_OVF       0
`define FXOS_STAT_OVF_LAST  1
`define FXOS_FMT_FRAC_LO    16

// ============================================================
// Reset values and bus answers
`define FXOS_RST_SIGNED     1'b1
`define FXOS_RST_OVF        2'h0
`define FXOS_RST_QUANT      2'h0
`define FXOS_RESP_OKAY      2'h0
`define FXOS_RESP_SLVERR    2'h2

`endif

// *** logic/fxos_conv_if.sv ***
// Carrier between the output stage and its format converter.
// Assumes the converter is purely combinational.
`timescale 1ns/1ps
interface fxos_conv_if
    import fxos_pkg::*;
#(
    parameter int IN_W  = 16,
    parameter int OUT_W = 16
);
    logic signed [IN_W-1:0]  din;
    logic                    out_signed;
    fxos_ovf_type            ovf_mode;
    fxos_quant_type          quant_mode;
    logic        [OUT_W-1:0] dout;
    logic                    ovf;

    modport stage (output din, out_signed, ovf_mode, quant_mode, input dout, ovf);
    modport conv  (input din, out_signed, ovf_mode, quant_mode, output dout, ovf);
endinterface

// *** logic/fxos_convert.sv ***
// Combinational conversion of a full-precision signed result to the output format.
// Assumes a signed two's complement input with IN_FRAC fraction bits.
`timescale 1ns/1ps
module fxos_convert
    import fxos_pkg::*;
#(
    parameter int IN_W     = 16,
    parameter int IN_FRAC  = 8,
    parameter int OUT_W    = 16,
    parameter int OUT_FRAC = 8
)
(
    fxos_conv_if.conv cv
);
    // ============================================================
    // Geometry
    localparam int OF  = (OUT_FRAC > OUT_W) ? OUT_W : OUT_FRAC;
    localparam int LS  = (OF > IN_FRAC) ? OF - IN_FRAC : 0;
    localparam int SH2 = ((IN_FRAC > OF) ? IN_FRAC - OF : 0) + 2;
    localparam int XW  = IN_W + LS + 2;
    localparam int QW  = XW - SH2 + 1;
    localparam int CW  = (QW > OUT_W + 1) ? QW : OUT_W + 1;

    localparam logic signed [CW-1:0] SMAX = $signed({{(CW-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}});
    localparam logic signed [CW-1:0] SMIN = ~SMAX;
    localparam logic signed [CW-1:0] UMAX = $signed({{(CW-OUT_W){1'b0}}, {OUT_W{1'b1}}});

    // ============================================================
    // Quantization first, two guard zeros keep the slices legal
    wire        [XW-1:0]     x_w    = {cv.din, {(LS+2){1'b0}}};
    wire        [CW+SH2-1:0] xs_w   = {{(CW+SH2-XW){x_w[XW-1]}}, x_w};
    wire signed [CW-1:0]     kept_w = $signed(xs_w[CW+SH2-1:SH2]);
    wire                     half_w = xs_w[SH2-1];
    wire                     rest_w = |xs_w[SH2-2:0];
    wire                     neg_w  = kept_w[CW-1];
    wire                     sym_w  = half_w & (rest_w | ~neg_w);
    wire                     conv_w = half_w & (rest_w | kept_w[0]);
    wire                     inc_w  = (cv.quant_mode == FXOS_Q_SYM)  ? sym_w  :
                                      (cv.quant_mode == FXOS_Q_CONV) ? conv_w :
                                      1'b0;
    wire signed [CW-1:0]     q_w    = kept_w + $signed({{(CW-1){1'b0}}, inc_w});

    // ============================================================
    // Overflow on the rounded value
    wire hi_w   = cv.out_signed ? (q_w > SMAX) : (q_w > UMAX);
    wire lo_w   = cv.out_signed ? (q_w < SMIN) : q_w[CW-1];
    wire [OUT_W-1:0] top_w = cv.out_signed ? SMAX[OUT_W-1:0] : UMAX[OUT_W-1:0];
    wire [OUT_W-1:0] bot_w = cv.out_signed ? SMIN[OUT_W-1:0] : {OUT_W{1'b0}};
    wire             sat_w = (cv.ovf_mode == FXOS_OVF_SAT);

    // Flag mode falls through to wrap: same gates, status still records it
    assign cv.dout = (sat_w && hi_w) ? top_w :
                     (sat_w && lo_w) ? bot_w :
                     q_w[OUT_W-1:0];
    assign cv.ovf  = hi_w | lo_w;
endmodule

// *** logic/fxos_pkg.sv ***
// Types shared by the output stage and its converter.
// Assumes fxos_cfg.svh is on the include path.
package fxos_pkg;

    // ============================================================
    // Mode types
    typedef enum logic [1:0] {FXOS_OVF_WRAP, FXOS_OVF_SAT, FXOS_OVF_FLAG} fxos_ovf_type;
    typedef enum logic [1:0] {FXOS_Q_TRUNC, FXOS_Q_SYM, FXOS_Q_CONV} fxos_quant_type;

    // Unused code 3 falls back to the plain mode
    function automatic fxos_ovf_type fxos_ovf_decode(input logic [1:0] f);
        fxos_ovf_decode = (f == 2'h3) ? FXOS_OVF_WRAP : fxos_ovf_type'(f);
    endfunction

    function automatic fxos_quant_type fxos_quant_decode(input logic [1:0] f);
        fxos_quant_decode = (f == 2'h3) ? FXOS_Q_TRUNC : fxos_quant_type'(f);
    endfunction

endpackage

// *** logic/fxos_stage.sv ***
// Fixed-point output stage: format conversion, latency pipeline, AXI4-Lite registers.
// Assumes upstream holds din_in stable around each sample_ce_in strobe.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "fxos_cfg.svh"
module fxos_stage
    import fxos_pkg::*;
#(
    parameter int IN_W     = 16,
    parameter int IN_FRAC  = 8,
    parameter int OUT_W    = 16,
    parameter int OUT_FRAC = 8,
    parameter int LATENCY  = 1,
    parameter int ADDR_W   = 12
)
(
    // Clock, reset, global freeze
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              ce_in,

    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,

    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,

    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,

    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,

    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,

    // Upstream datapath
    input  wire logic [IN_W-1:0]   din_in,
    input  wire logic              sample_ce_in,
    input  wire logic              dp_rst_in,
    input  wire logic              dp_en_in,

    // Downstream datapath
    output logic [OUT_W-1:0]       dout_out,
    output logic                   ovf_out
);
    // ============================================================
    // Decode helpers
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        reg_sel[0] = (w == `FXOS_OFF_CTRL);
        reg_sel[1] = (w == `FXOS_OFF_STATUS);
        reg_sel[2] = (w == `FXOS_OFF_COUNT);
        reg_sel[3] = (w == `FXOS_OFF_FORMAT);
    endfunction

    function automatic logic [1:0] resp_for(input logic [3:0] sel);
        resp_for = (|sel) ? `FXOS_RESP_OKAY : `FXOS_RESP_SLVERR;
    endfunction

    // ============================================================
    // Declarations
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;

    logic              out_signed_q;
    logic [1:0]        ovf_field_q;
    logic [1:0]        quant_field_q;
    logic              ovf_sticky_q;
    logic              ovf_sticky_d;
    logic [31:0]       sample_cnt_q;
    logic [OUT_W:0]    pipe_q [LATENCY];

    // ============================================================
    // Bus decode
    wire         aw_hs_w    = s_axi_awvalid_in & awready_q;
    wire         w_hs_w     = s_axi_wvalid_in & wready_q;
    wire         b_hs_w     = bvalid_q & s_axi_bready_in;
    wire         ar_hs_w    = s_axi_arvalid_in & arready_q;
    wire         r_hs_w     = rvalid_q & s_axi_rready_in;
    // Both halves held and no response pending
    wire         do_wr_w    = ~awready_q & ~wready_q & ~bvalid_q;
    wire [3:0]   wsel_w     = reg_sel(awaddr_q);
    wire [3:0]   rsel_w     = reg_sel(s_axi_araddr_in);
    wire         wr_ctrl_w  = do_wr_w & wsel_w[0] & wstrb_q[0];
    wire         wr_stat_w  = do_wr_w & wsel_w[1] & wstrb_q[0];

    // ============================================================
    // Sample timing
    // Reset and enable are only looked at on sample strobes
    wire         dp_clr_w   = sample_ce_in & dp_rst_in;
    // Reset wins even with enable low
    wire         adv_w      = sample_ce_in & dp_en_in & ~dp_rst_in;

    // ============================================================
    // Converter
    fxos_conv_if #(.IN_W(IN_W), .OUT_W(OUT_W)) conv_bus ();

    assign conv_bus.din        = $signed(din_in);
    assign conv_bus.out_signed = out_signed_q;
    assign conv_bus.ovf_mode   = fxos_ovf_decode(ovf_field_q);
    assign conv_bus.quant_mode = fxos_quant_decode(quant_field_q);

    fxos_convert #(
        .IN_W     (IN_W),
        .IN_FRAC  (IN_FRAC),
        .OUT_W    (OUT_W),
        .OUT_FRAC (OUT_FRAC)
    ) u_convert (
        .cv (conv_bus.conv)
    );

    // ============================================================
    // Read mux
    wire [31:0] ctrl_word_w = {27'h0, quant_field_q, ovf_field_q, out_signed_q};
    wire [31:0] stat_word_w = {30'h0, pipe_q[0][OUT_W], ovf_sticky_q};
    wire [12:0] fmt_w_w     = 13'(OUT_W);
    wire [12:0] fmt_f_w     = 13'(OUT_FRAC);
    wire [31:0] fmt_word_w  = {3'h0, fmt_f_w, 3'h0, fmt_w_w};
    wire [31:0] rd_word_w   = rsel_w[0] ? ctrl_word_w :
                              rsel_w[1] ? stat_word_w :
                              rsel_w[2] ? sample_cnt_q :
                              rsel_w[3] ? fmt_word_w :
                              32'h0;

    // ============================================================
    // Write channel
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `FXOS_RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end
        else if (ce_in)
        begin
            if (aw_hs_w)
            begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr_in;
            end
            if (w_hs_w)
            begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end
            if (do_wr_w)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= resp_for(wsel_w);
            end
            if (b_hs_w)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ============================================================
    // Read channel
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `FXOS_RESP_OKAY;
            rdata_q   <= 32'h0;
        end
        else if (ce_in)
        begin
            if (ar_hs_w)
            begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rresp_q   <= resp_for(rsel_w);
                rdata_q   <= rd_word_w;
            end
            else if (r_hs_w)
            begin
                arready_q <= 1'b1;
                rvalid_q  <= 1'b0;
            end
        end
    end

    // ============================================================
    // Control register
    // Modes may change at any time; they take effect on the next sample
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            out_signed_q  <= `FXOS_RST_SIGNED;
            ovf_field_q   <= `FXOS_RST_OVF;
            quant_field_q <= `FXOS_RST_QUANT;
        end
        else if (ce_in && wr_ctrl_w)
        begin
            out_signed_q  <= wdata_q[`FXOS_CTRL_SIGNED];
            ovf_field_q   <= wdata_q[`FXOS_CTRL_OVF_LO +: 2];
            quant_field_q <= wdata_q[`FXOS_CTRL_Q_LO +: 2];
        end
    end

    // ============================================================
    // Overflow status, set wins over write-one-to-clear
    always_comb
    begin
        ovf_sticky_d = ovf_sticky_q;
        if (wr_stat_w && wdata_q[`FXOS_STAT_OVF])
        begin
            ovf_sticky_d = 1'b0;
        end
        if (adv_w && conv_bus.ovf)
        begin
            ovf_sticky_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            ovf_sticky_q <= 1'b0;
        end
        else if (ce_in)
        begin
            ovf_sticky_q <= ovf_sticky_d;
        end
    end

    // ============================================================
    // Sample counter, part of datapath state
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in || (ce_in && dp_clr_w))
        begin
            sample_cnt_q <= 32'h0;
        end
        else if (ce_in && adv_w)
        begin
            sample_cnt_q <= sample_cnt_q + 32'h1;
        end
    end

    // ============================================================
    // Latency pipeline, one step per sample period
    // A zero latency is not offered: outputs must leave a flip-flop
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in || (ce_in && dp_clr_w))
        begin
            for (int i = 0; i < LATENCY; i++)
            begin
                pipe_q[i] <= '0;
            end
        end
        else if (ce_in && adv_w)
        begin
            pipe_q[0] <= {conv_bus.ovf, conv_bus.dout};
            for (int i = 1; i < LATENCY; i++)
            begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // ============================================================
    // Outputs
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out  = wready_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rresp_out   = rresp_q;
    assign s_axi_rdata_out   = rdata_q;
    assign dout_out          = pipe_q[LATENCY-1][OUT_W-1:0];
    assign ovf_out           = pipe_q[LATENCY-1][OUT_W];
endmodule

// *** testbench/fxos_stage_props.sv ***
// Port-level checks for fxos_stage.
// Assumes one clock domain and ce_in held high by the bench.
`timescale 1ns/1ps
module fxos_stage_props
    import fxos_pkg::*;
#(
    parameter int OUT_W = 16
)
(
    input wire logic             core_clk_in,
    input wire logic             srst_in,
    input wire logic             ce_in,
    input wire logic             sample_ce_in,
    input wire logic             dp_rst_in,
    input wire logic             dp_en_in,
    input wire logic [OUT_W-1:0] dout_out,
    input wire logic             ovf_out,
    input wire logic             s_axi_awvalid_in,
    input wire logic             s_axi_awready_out,
    input wire logic             s_axi_wvalid_in,
    input wire logic             s_axi_wready_out,
    input wire logic             s_axi_bvalid_out,
    input wire logic             s_axi_bready_in,
    input wire logic             s_axi_arvalid_in,
    input wire logic             s_axi_arready_out,
    input wire logic             s_axi_rvalid_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    wire adv_w = ce_in && sample_ce_in;

    // ============================================================
    // Sequences
    sequence both_take;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence b_wait;
        !s_axi_bvalid_out ##1 s_axi_bvalid_out;
    endsequence

    // ============================================================
    // Datapath
    chk_idle_hold: assert property (
        !adv_w |=> $stable(dout_out) && $stable(ovf_out))
        else $error("output moved without a strobe");
    chk_en_hold: assert property (
        adv_w && !dp_en_in && !dp_rst_in |=> $stable(dout_out) && $stable(ovf_out))
        else $error("output moved while disabled");
    chk_dp_reset: assert property (
        adv_w && dp_rst_in |=> dout_out == '0 && !ovf_out)
        else $error("datapath reset did not clear output");
    chk_global_rst: assert property (
        $fell(srst_in) |-> dout_out == '0 && !ovf_out && !s_axi_bvalid_out
            && !s_axi_rvalid_out && s_axi_awready_out)
        else $error("outputs not cleared by reset");

    // ============================================================
    // Register bus
    chk_b_latency: assert property (both_take |=> b_wait)
        else $error("write answer not two cycles after handshake");
    chk_aw_block: assert property (both_take |=> !s_axi_awready_out [*2])
        else $error("second write accepted while pending");
    chk_b_release: assert property (
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out)
        else $error("write answer not released");
    chk_r_latency: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read answer not one cycle after handshake");
endmodule

// *** testbench/fxos_upstream.sv ***
// Upstream producer model: one sample strobe every DIV clocks, operands inverted between strobes.
// Assumes the bench sets the next operands at least one clock before a strobe.
`timescale 1ns/1ps
module fxos_upstream
#(
    parameter int DIV = 3
)
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // Operands asked for by the bench
    input  wire logic [15:0] req_din_in,
    input  wire logic        req_en_in,
    input  wire logic        req_rst_in,
    // Lines into the stage
    output logic             strb_out,
    output logic [15:0]      din_out,
    output logic             en_out,
    output logic             rst_out
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       strb_q;

    // ============================================================
    // Strobe at system rate
    assign cnt_d = (cnt_q == 4'(DIV - 1)) ? 4'h0 : cnt_q + 4'h1;
    always_ff @(posedge clk_in)
    begin
        cnt_q  <= srst_in ? 4'h0 : cnt_d;
        strb_q <= !srst_in && (cnt_d == 4'h0);
    end

    // Off-strobe junk, so a stage sampling at the wrong cycle is caught
    assign strb_out = strb_q;
    assign din_out  = strb_q ? req_din_in : ~req_din_in;
    assign en_out   = strb_q ? req_en_in : ~req_en_in;
    assign rst_out  = strb_q ? req_rst_in : ~req_rst_in;
endmodule

// *** testbench/tb_fxos_stage.sv ***
// Self-checking bench for fxos_stage: all modes, reset, enable, registers.
// Assumes design files, fxos_upstream and fxos_stage_props compiled first.
`timescale 1ns/1ps
module tb_fxos_stage;
    logic        clk, srst, ce;
    logic [11:0] aw_a, ar_a;
    logic        aw_v, w_v, b_r, ar_v, r_r;
    logic [31:0] w_d, r_d;
    logic [1:0]  b_s, r_s, rs;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [7:0]  dout;
    logic        ovf, strb, dpen, dprst, rq_e, rq_r;
    logic [15:0] din, rq_d;
    logic [8:0]  p0, p1;
    int          bad_count, check_count, sg, om, qm, cnt, k;
    logic [15:0] tbl [8] = '{16'h0018, 16'h0028, 16'hffe8, 16'hffd8,
                             16'h07f8, 16'h8000, 16'h7fff, 16'hfff0};

    fxos_stage #(.OUT_W(8), .OUT_FRAC(4), .LATENCY(2)) u_fxos_stage (
        .core_clk_in(clk), .srst_in(srst), .ce_in(ce),
        .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
        .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
        .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_s), .s_axi_bvalid_out(b_v),
        .s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
        .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_s),
        .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .din_in(din),
        .sample_ce_in(strb), .dp_rst_in(dprst), .dp_en_in(dpen),
        .dout_out(dout), .ovf_out(ovf));

    fxos_upstream #(.DIV(3)) u_fxos_upstream (.clk_in(clk), .srst_in(srst),
        .req_din_in(rq_d), .req_en_in(rq_e), .req_rst_in(rq_r),
        .strb_out(strb), .din_out(din), .en_out(dpen), .rst_out(dprst));

    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // Reporting
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk_dp(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch sample at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_bus(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch bus at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task hang;
        bad_count++;
        $display("mismatch wait at %0t got %h exp %h", $time, 1'b0, 1'b1);
        report_and_stop;
    endtask

    // ============================================================
    // Bus master
    task axw(input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        aw_a <= a; w_d <= d; aw_v <= 1; w_v <= 1; b_r <= 1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (aw_v && aw_rdy) aw_v <= 0;
            if (w_v && w_rdy) w_v <= 0;
            if (b_v && b_r)
            begin
                rs = b_s;
                b_r <= 0;
                break;
            end
        end
        if (i == 50) hang;
    endtask

    task axr(input logic [11:0] a, input logic [33:0] exp);
        int i;
        @(posedge clk);
        ar_a <= a; ar_v <= 1; r_r <= 1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (ar_v && ar_rdy) ar_v <= 0;
            if (r_v && r_r)
            begin
                chk_bus({r_s, r_d}, exp);
                r_r <= 0;
                break;
            end
        end
        if (i == 50) hang;
    endtask

    // ============================================================
    // Reference model: Q8.8 in, 8 bits with 4 fraction bits out
    function automatic logic [8:0] conv(input logic [15:0] d);
        int v, q, f, lo, hi, r;
        v = $signed(d);
        q = v >>> 4;
        f = v & 15;
        if (qm == 1 && (f > 8 || (f == 8 && v >= 0))) q++;
        if (qm == 2 && (f > 8 || (f == 8 && (q & 1) == 1))) q++;
        lo = sg ? -128 : 0;
        hi = sg ? 127 : 255;
        r = (om == 1) ? ((q < lo) ? lo : (q > hi) ? hi : q) : q;
        conv = {(q < lo) || (q > hi), r[7:0]};
    endfunction

    task step(input logic [15:0] d, input logic e, input logic r);
        int i;
        @(posedge clk);
        rq_d <= d; rq_e <= e; rq_r <= r;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (strb) break;
        end
        if (i == 20) hang;
        if (r)
        begin
            p0 = '0; p1 = '0; cnt = 0;
        end
        else if (e)
        begin
            p1 = p0; p0 = conv(d); cnt++;
        end
        #1 chk_dp({ovf, dout}, p1);
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        srst = 1; ce = 1; aw_v = 0; w_v = 0; b_r = 0; ar_v = 0; r_r = 0;
        aw_a = '0; ar_a = '0; w_d = '0; rq_d = '0; rq_e = 0; rq_r = 0;
        p0 = '0; p1 = '0; cnt = 0; bad_count = 0; check_count = 0;
        void'($urandom(32'hadbb64b5));
        repeat (12) @(posedge clk);
        srst <= 0;
        #1 chk_dp({ovf, dout}, 9'h0);
        axr(12'h00c, {2'h0, 32'h0004_0008});
        axr(12'h000, {2'h0, 32'h1});
        axr(12'h010, {2'h2, 32'h0});
        for (sg = 0; sg < 2; sg++)
            for (om = 0; om < 4; om++)
                for (qm = 0; qm < 4; qm++)
                begin
                    axw(12'h000, 32'(sg + om * 2 + qm * 8));
                    chk_bus({rs, 32'h0}, 34'h0);
                    for (k = 0; k < 12; k++)
                        step(k < 8 ? tbl[k] : 16'($urandom), k < 10, k == 11);
                end
        for (k = 0; k < 3; k++)
            step(16'($urandom), 1'b1, 1'b0);
        // Park with enable low so no strobe advances under the reads
        step(16'h0, 1'b0, 1'b0);
        axr(12'h008, {2'h0, 32'(cnt)});
        axr(12'h004, {2'h0, 30'h0, p0[8], 1'b1});
        axw(12'h004, 32'h1);
        chk_bus({rs, 32'h0}, 34'h0);
        axr(12'h004, {2'h0, 30'h0, p0[8], 1'b0});
        report_and_stop;
    end
endmodule

bind fxos_stage fxos_stage_props #(.OUT_W(OUT_W)) u_fxos_stage_props (
    .core_clk_in, .srst_in, .ce_in, .sample_ce_in, .dp_rst_in, .dp_en_in,
    .dout_out, .ovf_out, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rvalid_out);
